// ===== src/touch_adc_cfg.svh
/*
 * Constants of the touch converter serial control: control byte layout,
 * serial phase counts, channel codes and reset values.
 * Assumes inclusion by bare name from the design files under src/.
 */
`ifndef TOUCH_ADC_CFG_SVH
`define TOUCH_ADC_CFG_SVH

// control byte fields, most significant bit first on the wire
`define CMD_START_POS 7
`define CMD_CH_MSB 6
`define CMD_CH_LSB 4
`define CMD_MODE_POS 3
`define CMD_REF_POS 2
`define CMD_PD_HI_POS 1
`define CMD_PD_LO_POS 0

// count of bits held after the start bit when acquisition / byte end
`define CMD_ACQ_COUNT 3'h2
`define CMD_DONE_COUNT 3'h6
`define CMD_COUNT_STEP 3'h1

// result lengths in serial clocks
`define RESULT_BITS_12 4'hC
`define RESULT_BITS_8 4'h8
`define RESULT_LAST 4'h1
`define RESULT_STEP 4'h1

// channel codes that drive the touch panel (Y, Z1, Z2, X)
`define CH_TOUCH_Y 3'h1
`define CH_TOUCH_Z1 3'h3
`define CH_TOUCH_Z2 3'h4
`define CH_TOUCH_X 3'h5

// reset values
`define PD_RESET 2'h0
`define CH_RESET 3'h0
`define BYTE_RESET 8'h00
`define RESULT_RESET 12'h000
`define REF_ON_RESET 1'b0
`define PEN_EN_RESET 1'b1
// pin order {pen_sense, din, cs_n, sclk}; cs_n and pen_sense idle high
`define PIN_SYNC_RESET 4'hA
`define PIN_SCLK 0
`define PIN_CS_N 1
`define PIN_DIN 2
`define PIN_PEN 3

`endif

// ===== src/touch_adc_pkg.sv
/*
 * Types of the touch converter serial control.
 * Assumes nothing beyond a SystemVerilog compiler; compiled first.
 */
package touch_adc_pkg;
  typedef logic [2:0] channel_t;
  typedef logic [1:0] power_down_t;
  typedef logic [11:0] result_t;
  typedef logic [3:0] pins_t;
  typedef logic [7:0] ctrl_byte_t;
  typedef enum logic {CMD_WAIT, CMD_SHIFT} cmd_state_e;
  typedef enum logic [1:0] {
    CONV_IDLE,
    CONV_ARMED,
    CONV_SHIFT,
    CONV_EXTRA
  } conv_state_e;
endpackage

// ===== src/pin_sync.sv
/*
 * Two-flop synchroniser for the serial pins of the touch converter.
 * Assumes pins are asynchronous to clock_in; reset is already released
 * synchronously by the caller.
 */
`include "touch_adc_cfg.svh"

module pin_sync (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire touch_adc_pkg::pins_t pins_in,
  output touch_adc_pkg::pins_t pins_out
);
  import touch_adc_pkg::*;

  pins_t meta;

  // meta feeds only the second stage
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      meta <= `PIN_SYNC_RESET;
      pins_out <= `PIN_SYNC_RESET;
    end else begin
      meta <= pins_in;
      pins_out <= meta;
    end
  end
endmodule

// ===== src/touch_adc_serial_control.sv
/*
 * Serial command and conversion sequencing of a resistive touch screen
 * converter: control byte decode, acquire/hold phases, result shifting,
 * power-down, reference and pen interrupt control.
 * Assumes clock_in at 40 MHz, well above the serial clock so that every
 * serial edge is seen after synchronisation; the analogue core presents
 * its conversion result on result_in when busy rises.
 */
// Functional notes
// - a full conversion takes three eight-clock transfers, 24 clocks
// - acquisition starts after channel bits; conversion four clocks later
// - conversion holds the sample; single-ended mode turns drivers off
// - conversion runs over the twelve clocks after the control byte
// - ratiometric mode keeps drivers on and uses a thirteenth clock
// - result output held low during the three padding clocks
// - command input ignored until a high start bit arrives
// - byte order: start, channel, resolution, reference, power-down
// - channel and reference bits steer mux, drivers and reference
// - resolution bit low gives twelve bits, high gives eight
// - reference bit high single-ended, low ratiometric across drivers
// - new byte may start every 15th (12-bit) or 11th (8-bit) clock
// - reference power latched at busy rise; extra byte turns it off
// - power-down 00: low power between conversions, pen irq enabled
// - power-down 01: reference off, converter on, pen irq disabled
// - power-down 10: reference on, converter off, pen irq enabled
// - power-down 11: all powered, pen irq disabled
// - reference power independent of converter power
// - pen irq re-enabled at end of conversion when last byte had 0
// - pen irq forced low for touch channels, high for others
// - eight-bit mode completes four clocks sooner
`include "touch_adc_cfg.svh"

module touch_adc_serial_control (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic conversion_serial_clock_in,
  input wire logic chip_select_n_in,
  input wire logic command_data_in,
  input wire logic pen_sense_n_in,
  input wire touch_adc_pkg::result_t result_in,
  output logic result_data_out,
  output logic result_oe_n_out,
  output logic busy_out,
  output logic busy_oe_n_out,
  output touch_adc_pkg::channel_t channel_select_out,
  output logic reference_select_out,
  output logic resolution_8bit_out,
  output touch_adc_pkg::power_down_t power_down_select_out,
  output logic acquire_out,
  output logic sample_hold_out,
  output logic panel_drivers_on_out,
  output logic y_minus_switch_out,
  output logic reference_power_on_out,
  output logic converter_power_on_out,
  output logic pen_touch_irq_out
);
  import touch_adc_pkg::*;

  logic [1:0] rst_pipe;
  logic rst_n;
  pins_t pins_raw;
  pins_t pins_s;
  logic sclk_prev;

  cmd_state_e cmd_state;
  logic [2:0] cmd_count;
  logic [5:0] cmd_bits;
  ctrl_byte_t ctl_byte;
  channel_t acq_channel;

  conv_state_e conv_state;
  logic [3:0] conv_left;
  result_t result_sr;
  logic busy;
  logic dout;
  logic acquire;
  logic hold;
  logic ref_on;
  logic pen_enable;

  // release of the asynchronous reset is synchronised here
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n = rst_pipe[1];

  assign pins_raw = {pen_sense_n_in, command_data_in, chip_select_n_in,
                     conversion_serial_clock_in};

  pin_sync u_pin_sync (
    .clock_in(clock_in),
    .rst_n_in(rst_n),
    .pins_in(pins_raw),
    .pins_out(pins_s)
  );

  wire sclk_s = pins_s[`PIN_SCLK];
  wire cs_active = ~pins_s[`PIN_CS_N];
  wire din_s = pins_s[`PIN_DIN];
  wire pen_s = pins_s[`PIN_PEN];

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      sclk_prev <= 1'b0;
    end else begin
      sclk_prev <= sclk_s;
    end
  end

  // serial clock edges only count while the frame is open
  wire sclk_rise = cs_active & sclk_s & ~sclk_prev;
  wire sclk_fall = cs_active & ~sclk_s & sclk_prev;

  // command byte decode
  wire start_seen = sclk_rise & (cmd_state == CMD_WAIT) & din_s;
  wire shift_en = sclk_rise & (cmd_state == CMD_SHIFT);
  wire acq_begin = shift_en & (cmd_count == `CMD_ACQ_COUNT);
  wire byte_done = shift_en & (cmd_count == `CMD_DONE_COUNT);
  wire [7:0] next_byte = {1'b1, cmd_bits, din_s};
  wire [2:0] next_acq_channel = {cmd_bits[1:0], din_s};
  wire [2:0] next_cmd_count = cmd_count + `CMD_COUNT_STEP;

  // fields of the byte in force
  wire [2:0] ctl_channel = ctl_byte[`CMD_CH_MSB:`CMD_CH_LSB];
  wire ctl_mode = ctl_byte[`CMD_MODE_POS];
  wire ctl_ser = ctl_byte[`CMD_REF_POS];
  wire ctl_pd_hi = ctl_byte[`CMD_PD_HI_POS];
  wire ctl_pd_lo = ctl_byte[`CMD_PD_LO_POS];

  // eight-bit mode is four clocks shorter
  wire [3:0] result_len = ctl_mode ? `RESULT_BITS_8 : `RESULT_BITS_12;

  wire busy_edge = sclk_fall & (conv_state == CONV_ARMED);
  wire bit_edge = sclk_fall & (conv_state == CONV_SHIFT);
  wire eoc = bit_edge & (conv_left == `RESULT_LAST);
  wire extra_edge = sclk_fall & (conv_state == CONV_EXTRA);
  wire [3:0] next_conv_left = conv_left - `RESULT_STEP;

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      cmd_state <= CMD_WAIT;
      cmd_count <= 3'h0;
      cmd_bits <= 6'h00;
    end else if (!cs_active) begin
      cmd_state <= CMD_WAIT;
      cmd_count <= 3'h0;
    end else if (start_seen) begin
      cmd_state <= CMD_SHIFT;
      cmd_count <= 3'h0;
    end else if (shift_en) begin
      cmd_bits <= {cmd_bits[4:0], din_s};
      cmd_count <= next_cmd_count;
      if (byte_done) begin
        // free to take the next start bit while the conversion runs
        cmd_state <= CMD_WAIT;
      end
    end
  end

  // the byte in force changes only when a whole byte is in
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      ctl_byte <= `BYTE_RESET;
      acq_channel <= `CH_RESET;
    end else begin
      if (byte_done) begin
        ctl_byte <= next_byte;
      end
      if (acq_begin) begin
        acq_channel <= next_acq_channel;
      end
    end
  end

  // conversion sequencer, run on serial falling edges
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      conv_state <= CONV_IDLE;
      conv_left <= 4'h0;
      result_sr <= `RESULT_RESET;
      busy <= 1'b0;
      dout <= 1'b0;
    end else if (!cs_active) begin
      conv_state <= CONV_IDLE;
      busy <= 1'b0;
      dout <= 1'b0;
    end else if (byte_done) begin
      conv_state <= CONV_ARMED;
    end else begin
      case (conv_state)
        CONV_ARMED: begin
          if (busy_edge) begin
            busy <= 1'b1;
            dout <= 1'b0;
            conv_left <= result_len;
            result_sr <= result_in;
            conv_state <= CONV_SHIFT;
          end
        end
        CONV_SHIFT: begin
          if (bit_edge) begin
            busy <= 1'b0;
            dout <= result_sr[11];
            result_sr <= {result_sr[10:0], 1'b0};
            conv_left <= next_conv_left;
            if (eoc) begin
              conv_state <= ctl_ser ? CONV_IDLE : CONV_EXTRA;
            end
          end
        end
        CONV_EXTRA: begin
          if (extra_edge) begin
            dout <= 1'b0;
            conv_state <= CONV_IDLE;
          end
        end
        default: begin
          if (sclk_fall) begin
            dout <= 1'b0;
          end
        end
      endcase
    end
  end

  // acquire from channel bits to byte end, then hold until conversion ends
  wire hold_end = (eoc & ctl_ser) | extra_edge;
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      acquire <= 1'b0;
      hold <= 1'b0;
    end else if (!cs_active) begin
      acquire <= 1'b0;
      hold <= 1'b0;
    end else if (byte_done) begin
      acquire <= 1'b0;
      hold <= 1'b1;
    end else if (acq_begin) begin
      acquire <= 1'b1;
    end else if (hold_end) begin
      hold <= 1'b0;
    end
  end

  // power state; kept across frames since it is the device's mode
  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      ref_on <= `REF_ON_RESET;
      pen_enable <= `PEN_EN_RESET;
    end else begin
      if (busy_edge) begin
        ref_on <= ctl_pd_hi;
      end
      if (byte_done & next_byte[`CMD_PD_LO_POS]) begin
        pen_enable <= 1'b0;
      end else if (eoc & ~ctl_pd_lo) begin
        pen_enable <= 1'b1;
      end
    end
  end

  // output decode
  wire [2:0] meas_channel = hold ? ctl_channel : acq_channel;
  wire touch_ch = (meas_channel == `CH_TOUCH_X) |
                  (meas_channel == `CH_TOUCH_Y) |
                  (meas_channel == `CH_TOUCH_Z1) |
                  (meas_channel == `CH_TOUCH_Z2);
  wire measuring = acquire | hold;
  // single-ended drops the drivers at hold, ratiometric keeps them
  wire next_drivers = touch_ch & (acquire | (hold & ~ctl_ser));
  // between conversions, with pen irq enabled, the Y- switch grounds the panel for pen sensing
  wire next_y_minus = ~measuring & pen_enable;
  wire next_conv_power = ctl_pd_lo | measuring;
  wire next_pen_irq = measuring ? ~touch_ch :
                      (pen_enable ? pen_s : 1'b1);

  always_ff @(posedge clock_in or negedge rst_n) begin
    if (!rst_n) begin
      result_data_out <= 1'b0;
      result_oe_n_out <= 1'b1;
      busy_out <= 1'b0;
      busy_oe_n_out <= 1'b1;
      channel_select_out <= `CH_RESET;
      reference_select_out <= 1'b0;
      resolution_8bit_out <= 1'b0;
      power_down_select_out <= `PD_RESET;
      acquire_out <= 1'b0;
      sample_hold_out <= 1'b0;
      panel_drivers_on_out <= 1'b0;
      y_minus_switch_out <= 1'b0;
      reference_power_on_out <= `REF_ON_RESET;
      converter_power_on_out <= 1'b0;
      pen_touch_irq_out <= 1'b1;
    end else begin
      result_data_out <= dout;
      result_oe_n_out <= ~cs_active;
      busy_out <= busy;
      busy_oe_n_out <= ~cs_active;
      channel_select_out <= meas_channel;
      reference_select_out <= ctl_ser;
      resolution_8bit_out <= ctl_mode;
      power_down_select_out <= {ctl_pd_hi, ctl_pd_lo};
      acquire_out <= acquire;
      sample_hold_out <= hold;
      panel_drivers_on_out <= next_drivers;
      y_minus_switch_out <= next_y_minus;
      reference_power_on_out <= ref_on;
      converter_power_on_out <= next_conv_power;
      pen_touch_irq_out <= next_pen_irq;
    end
  end
endmodule

// ===== sim/touch_host_model.sv
/*
 * Host side of the touch converter serial link: frames, serial clock,
 * command bits, capture of result and busy just before each rising edge.
 * Assumes the bench clock_in; the serial clock stands low between frames.
 */
module touch_host_model (
  input wire logic clock_in,
  input wire logic result_data_in,
  input wire logic busy_in,
  output logic sclk_out,
  output logic cs_n_out,
  output logic din_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // six cycles a half period leaves margin over the pin sync delay
  localparam int HALF = 6;
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    din_out = 1'b0;
  end
  task automatic run(input logic [63:0] bits, input int n,
                     output logic [63:0] res, output logic [63:0] bsy);
    res = '0;
    bsy = '0;
    @(posedge clock_in);
    cs_n_out <= 1'b0;
    repeat (HALF) @(posedge clock_in);
    for (int i = 0; i < n; i++) begin
      din_out <= bits[n-1-i];
      repeat (HALF) @(posedge clock_in);
      res = {res[62:0], result_data_in};
      bsy = {bsy[62:0], busy_in};
      sclk_out <= 1'b1;
      repeat (HALF) @(posedge clock_in);
      sclk_out <= 1'b0;
    end
    repeat (HALF) @(posedge clock_in);
    cs_n_out <= 1'b1;
    // a released line shows the inverse, never a stale value
    din_out <= ~bits[0];
    repeat (HALF) @(posedge clock_in);
  endtask
endmodule

// ===== sim/touch_adc_serial_control_checker.sv
/*
 * Assertions on the ports of the touch converter serial control.
 * Assumes one clock_in domain; bound to the top module below.
 */
`include "touch_adc_cfg.svh"

module touch_adc_serial_control_checker (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic chip_select_n_in,
  input wire logic result_oe_n_out,
  input wire logic busy_out,
  input wire logic busy_oe_n_out,
  input wire touch_adc_pkg::channel_t channel_select_out,
  input wire logic reference_select_out,
  input wire touch_adc_pkg::power_down_t power_down_select_out,
  input wire logic acquire_out,
  input wire logic sample_hold_out,
  input wire logic panel_drivers_on_out,
  input wire logic reference_power_on_out,
  input wire logic converter_power_on_out,
  input wire logic pen_touch_irq_out
);
  import touch_adc_pkg::*;
  default clocking dc @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);
  wire idle = !acquire_out && !sample_hold_out;
  wire touch_ch = channel_select_out inside {`CH_TOUCH_Y, `CH_TOUCH_Z1,
    `CH_TOUCH_Z2, `CH_TOUCH_X};
  sequence s_busy_hold;
    busy_out[*8];
  endsequence
  sequence s_se_conv;
    (sample_hold_out && !acquire_out && reference_select_out)[*3];
  endsequence
  sequence s_df_conv;
    (sample_hold_out && !reference_select_out && touch_ch)[*3];
  endsequence
  property p_float;
    chip_select_n_in[*6] |-> result_oe_n_out && busy_oe_n_out;
  endproperty
  a_float: assert property (p_float)
    else $error("outputs not floated");
  property p_acq_hold;
    $fell(acquire_out) && !chip_select_n_in |-> sample_hold_out;
  endproperty
  a_acq_hold: assert property (p_acq_hold) else $error("no hold");
  property p_se_off;
    s_se_conv |-> !panel_drivers_on_out;
  endproperty
  a_se_off: assert property (p_se_off) else $error("drivers on");
  property p_df_on;
    s_df_conv |-> panel_drivers_on_out;
  endproperty
  a_df_on: assert property (p_df_on) else $error("drivers off");
  property p_busy;
    $rose(busy_out) |-> s_busy_hold ##[1:20] !busy_out;
  endproperty
  a_busy: assert property (p_busy) else $error("busy length");
  property p_ref_latch;
    $changed(reference_power_on_out) |-> ##[0:1] busy_out;
  endproperty
  a_ref_latch: assert property (p_ref_latch)
    else $error("ref moved");
  property p_pen_forced;
    (!idle)[*2] |-> pen_touch_irq_out == !touch_ch;
  endproperty
  a_pen_forced: assert property (p_pen_forced)
    else $error("pen level");
  property p_pen_off;
    (idle && power_down_select_out[0])[*3] |-> pen_touch_irq_out;
  endproperty
  a_pen_off: assert property (p_pen_off) else $error("pen enabled");
  property p_adc_on;
    !idle |-> converter_power_on_out;
  endproperty
  a_adc_on: assert property (p_adc_on) else $error("adc off");
endmodule

bind touch_adc_serial_control touch_adc_serial_control_checker chk (
  .clock_in, .rst_n_in, .chip_select_n_in, .result_oe_n_out, .busy_out,
  .busy_oe_n_out, .channel_select_out, .reference_select_out,
  .power_down_select_out, .acquire_out, .sample_hold_out,
  .panel_drivers_on_out, .reference_power_on_out, .converter_power_on_out,
  .pen_touch_irq_out
);

// ===== sim/touch_adc_serial_control_bench.sv
/*
 * Self-checking bench of the touch converter serial control: frames from
 * the host model, result and busy streams, power-down settings.
 * Assumes the package, design, checker and host model compiled first.
 */
module touch_adc_serial_control_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import touch_adc_pkg::*;
  localparam int LIMIT = 20000;
  logic clock_in, rst_n_in, pen_sense_n_in;
  wire logic conversion_serial_clock_in, chip_select_n_in, command_data_in;
  result_t result_in;
  logic result_data_out, result_oe_n_out, busy_out, busy_oe_n_out;
  channel_t channel_select_out;
  power_down_t power_down_select_out;
  logic reference_select_out, resolution_8bit_out, acquire_out;
  logic sample_hold_out, panel_drivers_on_out, y_minus_switch_out;
  logic reference_power_on_out, converter_power_on_out, pen_touch_irq_out;
  logic [63:0] r, b;
  int n_mismatch = 0;
  int tests_run = 0;
  int cycles = 0;
  touch_adc_serial_control dut (.clock_in, .rst_n_in,
    .conversion_serial_clock_in, .chip_select_n_in, .command_data_in,
    .pen_sense_n_in, .result_in, .result_data_out, .result_oe_n_out,
    .busy_out, .busy_oe_n_out, .channel_select_out, .reference_select_out,
    .resolution_8bit_out, .power_down_select_out, .acquire_out,
    .sample_hold_out, .panel_drivers_on_out, .y_minus_switch_out,
    .reference_power_on_out, .converter_power_on_out, .pen_touch_irq_out);
  touch_host_model host (.clock_in, .result_data_in(result_data_out),
    .busy_in(busy_out), .sclk_out(conversion_serial_clock_in),
    .cs_n_out(chip_select_n_in), .din_out(command_data_in));
  initial begin
    clock_in = 1'b0;
    forever #12.5 clock_in = ~clock_in;
  end
  task automatic chk(input logic [63:0] got, exp, input string what);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %0t %s", $time, what);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // busy is sampled once a serial clock, so its stream holds one bit per conversion
  task automatic frame(input logic [63:0] bits, input int n,
                       input logic [63:0] er, eb);
    host.run(bits, n, r, b);
    chk(r, er, "result stream");
    chk(b, eb, "busy stream");
  endtask
  always @(posedge clock_in) begin
    cycles++;
    if (cycles == LIMIT) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  initial begin
    rst_n_in = 1'b0;
    pen_sense_n_in = 1'b1;
    result_in = 12'hA5C;
    repeat (12) @(posedge clock_in);
    rst_n_in <= 1'b1;
    repeat (8) @(posedge clock_in);
    chk(result_oe_n_out & busy_oe_n_out, 1'h1, "float");
    chk(pen_touch_irq_out, 1'h1, "pen idle");
    chk(reference_power_on_out, 1'h0, "ref reset");
    frame({8'h94, 16'h0}, 24, {9'h0, 12'hA5C, 3'h0}, 64'h8000);
    chk(channel_select_out, 3'h1, "channel");
    chk(reference_select_out, 1'h1, "single ended");
    chk(resolution_8bit_out, 1'h0, "twelve bit");
    $display("test basic done");
    result_in <= 12'h3C6;
    frame({3'h0, 8'hD7, 16'h0}, 27, {12'h0, 12'h3C6, 3'h0}, 64'h8000);
    $display("test start bit done");
    result_in <= 12'hF0F;
    frame({8'hBB, 16'h0}, 24, {9'h0, 8'hF0, 7'h0}, 64'h8000);
    chk(resolution_8bit_out, 1'h1, "eight bit");
    chk(reference_select_out, 1'h0, "ratiometric");
    chk(reference_power_on_out, 1'h1, "ref on");
    $display("test eight bit done");
    result_in <= 12'h5A3;
    frame({8'h94, 6'h0, 8'h94, 16'h0}, 38,
      {9'h0, 12'h5A3, 2'h0, 12'h5A3, 3'h0}, 64'h2000_8000);
    frame({8'h9C, 2'h0, 8'h9C, 16'h0}, 34,
      {9'h0, 8'h5A, 2'h0, 8'h5A, 7'h0}, 64'h0200_8000);
    $display("test overlap done");
    pen_sense_n_in <= 1'b0;
    for (int p = 0; p < 4; p++) begin
      frame({3'h6, 3'h5, p[1:0], 16'h0}, 24,
        {9'h0, 12'h5A3, 3'h0}, 64'h8000);
      repeat (8) @(posedge clock_in);
      chk(power_down_select_out, p[1:0], "pd kept");
      chk(reference_power_on_out, p[1], "ref power");
      chk(converter_power_on_out, p[0], "adc power");
      chk(pen_touch_irq_out, p[0], "pen");
      chk(y_minus_switch_out, !p[0], "y switch");
    end
    $display("test power-down done");
    tally_and_finish();
  end
endmodule
